// >>> rtl/tseq_params.svh
// Purpose: constants of the trigger sequencer
// Assumes: 200 MHz sys_clk, 32-bit register port
// Notes: offsets are byte addresses
`ifndef TSEQ_PARAMS_SVH
`define TSEQ_PARAMS_SVH
// ----------------------------------------------------
// register offsets
// ----------------------------------------------------
`define TSEQ_CTRL     12'h000
`define TSEQ_STAT     12'h004
`define TSEQ_TLIM     12'h010
`define TSEQ_RLO      12'h020
`define TSEQ_RHI      12'h024
`define TSEQ_ERISE    12'h030
`define TSEQ_EFALL    12'h034
`define TSEQ_PVAL     12'h040
`define TSEQ_PCARE    12'h044
`define TSEQ_LVLA     12'h100
`define TSEQ_LVLB     12'h104
// ----------------------------------------------------
// level word fields
// ----------------------------------------------------
`define TSEQ_LA_PSEL  0
`define TSEQ_LA_SSEL  5
`define TSEQ_LA_TGT   10
`define TSEQ_LA_DUR   14
`define TSEQ_LA_T0    16
`define TSEQ_LA_T1    19
`define TSEQ_LA_SEN   22
`define TSEQ_LA_CONS  23
`define TSEQ_LA_QUAL  24
`define TSEQ_LA_W     25
// ----------------------------------------------------
// control fields and reset values
// ----------------------------------------------------
`define TSEQ_C_ARM    0
`define TSEQ_C_TIME   1
`define TSEQ_C_STO    2
`define TSEQ_C_TRIG   4
`define TSEQ_C_SSEL   8
`define TSEQ_TMR_NS   400
`define TSEQ_CLK_MHZ  200
`define TSEQ_TMR_CYC  ((`TSEQ_TMR_NS * `TSEQ_CLK_MHZ + 999) / 1000)
`endif

// >>> rtl/tseq_pkg.sv
// Purpose: types of the trigger sequencer
// Assumes: nothing
// Notes: gray codes along the usual path
package tseq_pkg;
  typedef enum logic [2:0] {
    TSEQ_T_OFF   = 3'h0,
    TSEQ_T_START = 3'h1,
    TSEQ_T_STOP  = 3'h2,
    TSEQ_T_PAUSE = 3'h3,
    TSEQ_T_CONT  = 3'h4
  } tseq_tact_t;
  typedef enum logic [1:0] {
    TSEQ_TI_IDLE = 2'h0,
    TSEQ_TI_RUN  = 2'h1,
    TSEQ_TI_HALT = 2'h2,
    TSEQ_TI_DONE = 2'h3
  } tseq_tst_t;
  typedef enum logic [1:0] {
    TSEQ_S_IDLE = 2'h0,
    TSEQ_S_RUN  = 2'h1,
    TSEQ_S_DONE = 2'h3
  } tseq_st_t;
endpackage

// >>> rtl/tseq_timer_if.sv
// Purpose: link between sequencer and one timer
// Assumes: single clock
// Notes: action is a one-cycle entry command
`timescale 1ns/1ps
`default_nettype none
interface tseq_timer_if;
  tseq_pkg::tseq_tact_t action;
  logic [31:0]          limit;
  logic                 expired;
  modport ctl (output action, output limit, input expired);
  modport tmr (input action, input limit, output expired);
endinterface
`default_nettype wire

// >>> rtl/tseq_timer.sv
// Purpose: one global timer of the sequencer
// Assumes: limit in sys_clk cycles, at least 1
// Notes: actions override counting
`timescale 1ns/1ps
`default_nettype none
module tseq_timer (
  // clock and reset
  input wire logic   sys_clk,
  input wire logic   rst,
  // control
  tseq_timer_if.tmr  tif
);
  tseq_pkg::tseq_tst_t st;
  logic [31:0]         count;
  logic [31:0]         count_nx;
  assign count_nx = count + 32'h0000_0001;

  // --------------------------------------------------
  // timer state
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st          <= tseq_pkg::TSEQ_TI_IDLE;
      count       <= 32'h0;
      tif.expired <= 1'b0;
    end else begin
      case (tif.action)
        tseq_pkg::TSEQ_T_STOP: begin
          st          <= tseq_pkg::TSEQ_TI_IDLE;
          count       <= 32'h0;
          tif.expired <= 1'b0;
        end
        tseq_pkg::TSEQ_T_START: begin
          st          <= tseq_pkg::TSEQ_TI_RUN;
          count       <= 32'h0;
          tif.expired <= 1'b0;
        end
        tseq_pkg::TSEQ_T_PAUSE: begin
          if (st == tseq_pkg::TSEQ_TI_RUN) begin
            st <= tseq_pkg::TSEQ_TI_HALT;
          end
        end
        tseq_pkg::TSEQ_T_CONT: begin
          if (st == tseq_pkg::TSEQ_TI_HALT) begin
            st <= tseq_pkg::TSEQ_TI_RUN;
          end
        end
        default: begin
          if (st == tseq_pkg::TSEQ_TI_RUN) begin
            if (count_nx >= tif.limit) begin
              st          <= tseq_pkg::TSEQ_TI_DONE;
              count       <= 32'h0;
              tif.expired <= 1'b1;
            end else begin
              count <= count_nx;
            end
          end
        end
      endcase
    end
  end

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  stop_clears_a: assert property (
    tif.action == tseq_pkg::TSEQ_T_STOP |=> count == 32'h0 && !tif.expired)
    else $error("timer not cleared by stop");
  expiry_true_a: assert property (
    st == tseq_pkg::TSEQ_TI_RUN && tif.action == tseq_pkg::TSEQ_T_OFF
    && count_nx >= tif.limit |=> tif.expired && count == 32'h0)
    else $error("timer did not expire");
  pause_holds_a: assert property (
    st == tseq_pkg::TSEQ_TI_HALT && tif.action == tseq_pkg::TSEQ_T_OFF
    |=> st == tseq_pkg::TSEQ_TI_HALT && $stable(count))
    else $error("paused timer moved");
endmodule // tseq_timer
`default_nettype wire

// >>> rtl/tseq_top.sv
// Purpose: multi-level trigger sequencer
// Assumes: W at most 32, LEVELS at most 16
// Notes: one sample evaluated per smp_valid
//
// Decided for this implementation: the address-and-strobe port and the address map.
`include "tseq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tseq_top #(
  parameter int W      = 32,
  parameter int LEVELS = 12
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // samples
  input  wire logic        smp_valid,
  input  wire logic [W-1:0] smp_data,
  // acquisition side
  output logic             trig_pulse,
  output logic             store_en,
  output logic             triggered,
  output logic      [3:0]  cur_level
);
  localparam logic [3:0] LAST = 4'(LEVELS - 1);

  // --------------------------------------------------
  // configuration storage
  // --------------------------------------------------
  logic [W-1:0]  pat_val  [10];
  logic [W-1:0]  pat_care [10];
  logic [W-1:0]  value_window_lo [2];
  logic [W-1:0]  value_window_hi [2];
  logic [W-1:0]  edge_rise [2];
  logic [W-1:0]  edge_fall [2];
  logic [31:0]   tmr_lim  [2];
  logic [`TSEQ_LA_W-1:0] lvl_a [LEVELS];
  logic [15:0]   lvl_b    [LEVELS];
  logic          timing;
  logic [1:0]    sto_mode;
  logic [3:0]    trig_lvl;
  logic [4:0]    sto_sel;
  logic [W-1:0]  prev;
  tseq_pkg::tseq_st_t st;
  logic [15:0]   occ;
  logic [15:0]   run;

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  function automatic logic pat_hit(input logic [W-1:0] d,
                                   input logic [W-1:0] v,
                                   input logic [W-1:0] c);
    pat_hit = ((d ^ v) & c) == '0;
  endfunction

  function automatic logic pick(input logic [15:0] t,
                                input logic [4:0]  s);
    pick = t[s[3:0]] ^ s[4];
  endfunction

  function automatic logic [11:0] slot(input logic [11:0] base,
                                       input int          i,
                                       input int          step);
    slot = base + 12'(i * step);
  endfunction

  // --------------------------------------------------
  // resource terms
  // --------------------------------------------------
  tseq_timer_if tif0 ();
  tseq_timer_if tif1 ();
  logic [15:0] term;
  always_comb begin
    term = 16'h0;
    for (int i = 0; i < 10; i++) begin
      term[i] = pat_hit(smp_data, pat_val[i], pat_care[i]);
    end
    for (int r = 0; r < 2; r++) begin
      term[10 + r] = smp_data >= value_window_lo[r]
                  && smp_data <= value_window_hi[r];
    end
    for (int e = 0; e < 2; e++) begin
      term[12 + e] = timing
        && |((edge_rise[e] & smp_data & ~prev)
           | (edge_fall[e] & ~smp_data & prev));
    end
    term[14] = tif0.expired;
    term[15] = tif1.expired;
  end

  // --------------------------------------------------
  // level evaluation
  // --------------------------------------------------
  logic [`TSEQ_LA_W-1:0] la;
  logic [15:0] cnt;
  logic [15:0] occ_nx;
  logic [15:0] run_nx;
  logic [1:0]  dmode;
  logic        p;
  logic        hit;
  logic        is_last;
  logic        sec_ok;
  logic        prim_ok;
  logic        go;
  logic        arm_wr;
  logic        trig_hit;
  logic        enter;
  logic        sec_take;
  logic [3:0]  next_cur;
  logic [`TSEQ_LA_W-1:0] ln;

  assign arm_wr = reg_wr && reg_addr == `TSEQ_CTRL;
  assign go     = st == tseq_pkg::TSEQ_S_RUN && smp_valid;
  assign occ_nx = occ + 16'h0001;
  assign run_nx = run + 16'h0001;

  always_comb begin
    la      = lvl_a[cur_level];
    cnt     = lvl_b[cur_level];
    p       = pick(term, la[`TSEQ_LA_PSEL +: 5]);
    dmode   = timing ? la[`TSEQ_LA_DUR +: 2] : 2'h0;
    is_last = cur_level == LAST;
    sec_ok  = la[`TSEQ_LA_SEN]
           && pick(term, la[`TSEQ_LA_SSEL +: 5])
           && !is_last && dmode == 2'h0;
    hit     = 1'b0;
    case (dmode)
      2'h0: begin
        // with QUAL set, a true secondary term blocks a coincident count
        hit     = p && !(la[`TSEQ_LA_QUAL] && sec_ok);
        prim_ok = hit && occ_nx >= cnt;
      end
      2'h1: prim_ok = p && run_nx >= cnt;
      2'h2: prim_ok = !p && run != 16'h0 && run <= cnt;
      default: prim_ok = 1'b0;
    endcase
  end

  always_comb begin
    trig_hit = go && prim_ok && cur_level == trig_lvl;
    sec_take = go && !prim_ok && sec_ok;
    enter    = 1'b0;
    next_cur = cur_level;
    if (arm_wr) begin
      enter    = reg_wdata[`TSEQ_C_ARM];
      next_cur = 4'h0;
    end else if (go && prim_ok && !trig_hit && !is_last) begin
      enter    = 1'b1;
      next_cur = cur_level + 4'h1;
    end else if (sec_take) begin
      enter    = 1'b1;
      next_cur = la[`TSEQ_LA_TGT +: 4];
    end
  end

  // --------------------------------------------------
  // timers, commanded on level entry
  // --------------------------------------------------
  always_comb begin
    ln          = lvl_a[next_cur];
    tif0.limit  = tmr_lim[0];
    tif1.limit  = tmr_lim[1];
    tif0.action = tseq_pkg::TSEQ_T_OFF;
    tif1.action = tseq_pkg::TSEQ_T_OFF;
    if (enter) begin
      tif0.action = tseq_pkg::tseq_tact_t'(ln[`TSEQ_LA_T0 +: 3]);
      tif1.action = tseq_pkg::tseq_tact_t'(ln[`TSEQ_LA_T1 +: 3]);
    end
  end

  tseq_timer u_tmr0 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tif     (tif0)
  );
  tseq_timer u_tmr1 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tif     (tif1)
  );

  // --------------------------------------------------
  // register writes
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timing   <= 1'b0;
      sto_mode <= 2'h0;
      trig_lvl <= 4'h0;
      sto_sel  <= 5'h0;
      for (int i = 0; i < 10; i++) begin
        pat_val[i]  <= '0;
        pat_care[i] <= '0;
      end
      for (int i = 0; i < 2; i++) begin
        value_window_lo[i] <= '0;
        value_window_hi[i] <= '1;
        edge_rise[i]       <= '0;
        edge_fall[i]       <= '0;
        tmr_lim[i]         <= 32'(`TSEQ_TMR_CYC);
      end
      for (int j = 0; j < LEVELS; j++) begin
        lvl_a[j] <= '0;
        lvl_b[j] <= 16'h0;
      end
    end else if (reg_wr) begin
      if (reg_addr == `TSEQ_CTRL) begin
        timing   <= reg_wdata[`TSEQ_C_TIME];
        sto_mode <= reg_wdata[`TSEQ_C_STO +: 2];
        trig_lvl <= reg_wdata[`TSEQ_C_TRIG +: 4];
        sto_sel  <= reg_wdata[`TSEQ_C_SSEL +: 5];
      end
      for (int i = 0; i < 10; i++) begin
        if (reg_addr == slot(`TSEQ_PVAL, i, 8)) begin
          pat_val[i] <= reg_wdata[W-1:0];
        end
        if (reg_addr == slot(`TSEQ_PCARE, i, 8)) begin
          pat_care[i] <= reg_wdata[W-1:0];
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (reg_addr == slot(`TSEQ_RLO, i, 8)) begin
          value_window_lo[i] <= reg_wdata[W-1:0];
        end
        if (reg_addr == slot(`TSEQ_RHI, i, 8)) begin
          value_window_hi[i] <= reg_wdata[W-1:0];
        end
        if (reg_addr == slot(`TSEQ_ERISE, i, 8)) begin
          edge_rise[i] <= reg_wdata[W-1:0];
        end
        if (reg_addr == slot(`TSEQ_EFALL, i, 8)) begin
          edge_fall[i] <= reg_wdata[W-1:0];
        end
        if (reg_addr == slot(`TSEQ_TLIM, i, 4)) begin
          tmr_lim[i] <= reg_wdata;
        end
      end
      for (int j = 0; j < LEVELS; j++) begin
        if (reg_addr == slot(`TSEQ_LVLA, j, 8)) begin
          lvl_a[j] <= reg_wdata[`TSEQ_LA_W-1:0];
        end
        if (reg_addr == slot(`TSEQ_LVLB, j, 8)) begin
          lvl_b[j] <= reg_wdata[15:0];
        end
      end
    end
  end

  // --------------------------------------------------
  // run state and level
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st        <= tseq_pkg::TSEQ_S_IDLE;
      cur_level <= 4'h0;
    end else begin
      if (arm_wr) begin
        st <= reg_wdata[`TSEQ_C_ARM] ? tseq_pkg::TSEQ_S_RUN
                                     : tseq_pkg::TSEQ_S_IDLE;
      end else if (trig_hit) begin
        st <= tseq_pkg::TSEQ_S_DONE;
      end
      cur_level <= next_cur;
    end
  end

  // --------------------------------------------------
  // occurrence and duration counters
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      occ <= 16'h0;
      run <= 16'h0;
    end else if (arm_wr || enter) begin
      occ <= 16'h0;
      run <= 16'h0;
    end else if (go) begin
      if (hit) begin
        occ <= occ_nx;
      end else if (la[`TSEQ_LA_CONS]) begin
        occ <= 16'h0;
      end
      run <= p ? run_nx : 16'h0;
    end
  end

  // --------------------------------------------------
  // trigger and storage outputs
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trig_pulse <= 1'b0;
      triggered  <= 1'b0;
      store_en   <= 1'b0;
      prev       <= '0;
    end else begin
      trig_pulse <= trig_hit;
      if (arm_wr) begin
        triggered <= 1'b0;
      end else if (trig_hit) begin
        triggered <= 1'b1;
      end
      if (smp_valid) begin
        prev <= smp_data;
      end
      store_en <= 1'b0;
      if (smp_valid && st == tseq_pkg::TSEQ_S_DONE) begin
        store_en <= 1'b1;
      end else if (smp_valid && st == tseq_pkg::TSEQ_S_RUN) begin
        case (sto_mode)
          2'h0:    store_en <= 1'b1;
          2'h1:    store_en <= 1'b0;
          2'h2:    store_en <= pick(term, sto_sel);
          default: store_en <= 1'b0;
        endcase
      end
    end
  end

  // --------------------------------------------------
  // register reads
  // --------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (reg_addr == `TSEQ_CTRL) begin
      rd_mux = {19'h0, sto_sel, trig_lvl, sto_mode, timing,
                st == tseq_pkg::TSEQ_S_RUN};
    end
    if (reg_addr == `TSEQ_STAT) begin
      rd_mux = {24'h0, tif1.expired, tif0.expired,
                st == tseq_pkg::TSEQ_S_RUN, triggered, cur_level};
    end
    for (int i = 0; i < 10; i++) begin
      if (reg_addr == slot(`TSEQ_PVAL, i, 8)) rd_mux = 32'(pat_val[i]);
      if (reg_addr == slot(`TSEQ_PCARE, i, 8)) rd_mux = 32'(pat_care[i]);
    end
    for (int i = 0; i < 2; i++) begin
      if (reg_addr == slot(`TSEQ_RLO, i, 8)) begin
        rd_mux = 32'(value_window_lo[i]);
      end
      if (reg_addr == slot(`TSEQ_RHI, i, 8)) begin
        rd_mux = 32'(value_window_hi[i]);
      end
      if (reg_addr == slot(`TSEQ_ERISE, i, 8)) rd_mux = 32'(edge_rise[i]);
      if (reg_addr == slot(`TSEQ_EFALL, i, 8)) rd_mux = 32'(edge_fall[i]);
      if (reg_addr == slot(`TSEQ_TLIM, i, 4)) rd_mux = tmr_lim[i];
    end
    for (int j = 0; j < LEVELS; j++) begin
      if (reg_addr == slot(`TSEQ_LVLA, j, 8)) rd_mux = 32'(lvl_a[j]);
      if (reg_addr == slot(`TSEQ_LVLB, j, 8)) rd_mux = 32'(lvl_b[j]);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  primary_step_a: assert property (
    !arm_wr && go && prim_ok && !trig_hit && !is_last
    |=> cur_level == $past(cur_level) + 4'h1)
    else $error("primary branch did not advance");
  secondary_jump_a: assert property (
    !arm_wr && sec_take |=> cur_level == $past(la[`TSEQ_LA_TGT +: 4]))
    else $error("secondary branch target missed");
  level_stay_a: assert property (
    !arm_wr && go && !prim_ok && !sec_ok |=> $stable(cur_level))
    else $error("level moved with no branch");
  else_clears_a: assert property (
    !arm_wr && sec_take |=> occ == 16'h0)
    else $error("occurrence count kept on else branch");
  primary_wins_a: assert property (
    !arm_wr && go && prim_ok && sec_ok && !trig_hit
    |=> cur_level == $past(cur_level) + 4'h1)
    else $error("secondary beat primary");
  duration_noelse_a: assert property (
    dmode != 2'h0 || is_last |-> !sec_ok)
    else $error("else branch offered with duration");
  trig_single_a: assert property (
    trig_pulse |=> !trig_pulse ##1 !trig_pulse)
    else $error("trigger pulse repeated");
  store_none_a: assert property (
    st == tseq_pkg::TSEQ_S_RUN && sto_mode == 2'h1 |=> !store_en)
    else $error("sample stored with store none");
endmodule // tseq_top
`default_nettype wire

// >>> dv/tseq_smp_src.sv
// Purpose: sample source standing in for the target system
// Assumes: one sample per send call, one sys_clk wide
// Notes: data shows the inverse of the last value between samples
`timescale 1ns/1ps
`default_nettype none
module tseq_smp_src #(
  parameter int W = 32
) (
  // clock
  input  wire logic         sys_clk,
  // samples
  output logic              smp_valid,
  output logic [W-1:0]      smp_data
);
  initial begin
    smp_valid = 1'b0;
    smp_data  = '0;
  end
  // ----------------------------------------------------
  // one sample strobe
  // ----------------------------------------------------
  task automatic send(input logic [W-1:0] d);
    @(posedge sys_clk);
    smp_valid <= 1'b1;
    smp_data  <= d;
    @(posedge sys_clk);
    smp_valid <= 1'b0;
    smp_data  <= ~d;
  endtask
endmodule // tseq_smp_src
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: self-checking bench of the trigger sequencer
// Assumes: 200 MHz sys_clk, reset held 3 cycles
// Notes: each scenario re-arms the sequencer
`include "tseq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk, rst, reg_wr, reg_rd, smp_valid;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, smp_data, rv;
  logic        trig_pulse, store_en, triggered;
  logic [3:0]  cur_level;
  int          mismatches, checked, cycles;

  tseq_top u_tseq_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .smp_valid(smp_valid), .smp_data(smp_data),
    .trig_pulse(trig_pulse), .store_en(store_en), .triggered(triggered),
    .cur_level(cur_level));
  tseq_smp_src u_tseq_smp_src (.sys_clk(sys_clk), .smp_valid(smp_valid),
    .smp_data(smp_data));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end
  // ----------------------------------------------------
  // bus, sample and compare tasks
  // ----------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic smp(input logic [31:0] d);
    u_tseq_smp_src.send(d);
    #1;
  endtask
  function automatic logic [31:0] lvl(input logic [4:0] p, input logic [4:0] s,
                                      input logic [3:0] t, input logic e);
    return {9'h0, e, 8'h0, t, s, p};
  endfunction
  // ----------------------------------------------------
  // scenarios
  // ----------------------------------------------------
  task automatic t_branch;
    wr(`TSEQ_PVAL, 32'h11); wr(`TSEQ_PCARE, 32'hff);
    wr(`TSEQ_PVAL + 12'h8, 32'h22); wr(`TSEQ_PCARE + 12'h8, 32'hff);
    wr(`TSEQ_LVLA, lvl(5'h0, 5'h1, 4'h0, 1'b1));
    wr(`TSEQ_LVLB, 32'h2);
    wr(`TSEQ_LVLA + 12'h8, lvl(5'h0, 5'h2, 4'h0, 1'b1));
    wr(`TSEQ_CTRL, 32'h51);
    smp(32'h11); chk(cur_level, 0); chk(store_en, 1);
    smp(32'h22); chk(cur_level, 0);
    smp(32'h11); chk(cur_level, 0);
    smp(32'h11); chk(cur_level, 1);
    smp(32'h11); chk(cur_level, 2);
    smp(32'h33); chk(cur_level, 2);
  endtask
  task automatic t_trig;
    wr(`TSEQ_LVLA, 32'h0); wr(`TSEQ_LVLB, 32'h0);
    wr(`TSEQ_LVLA + 12'h8, lvl(5'h1, 5'h0, 4'h0, 1'b0));
    wr(`TSEQ_CTRL, 32'h15);
    smp(32'h22); chk(cur_level, 0); chk(store_en, 0);
    smp(32'h11); chk(cur_level, 1);
    smp(32'h22); chk(trig_pulse, 1); chk(triggered, 1);
    @(posedge sys_clk); #1 chk(trig_pulse, 0);
    smp(32'h22); chk(trig_pulse, 0); chk(cur_level, 1);
    rd(`TSEQ_STAT); chk(rv[4], 1);
  endtask
  task automatic t_range;
    wr(`TSEQ_RLO, 32'h10); wr(`TSEQ_RHI, 32'h20);
    wr(`TSEQ_LVLA, lvl(5'ha, 5'h0, 4'h0, 1'b0));
    wr(`TSEQ_LVLA + 12'h8, lvl(5'h10, 5'h0, 4'h0, 1'b0));
    wr(`TSEQ_CTRL, 32'h51);
    smp(32'h0f); chk(cur_level, 0);
    smp(32'h21); chk(cur_level, 0);
    smp(32'h20); chk(cur_level, 1);
    smp(32'h11); chk(cur_level, 1);
    smp(32'h12); chk(cur_level, 2);
  endtask
  task automatic t_timer;
    wr(`TSEQ_TLIM, 32'h6);
    wr(`TSEQ_LVLA, {13'h0, 3'h1, 16'h000e});
    wr(`TSEQ_CTRL, 32'h51);
    rd(`TSEQ_STAT); chk(rv[6], 0);
    repeat (8) @(posedge sys_clk);
    rd(`TSEQ_STAT); chk(rv[6], 1);
    smp(32'h5); chk(cur_level, 1);
    wr(`TSEQ_LVLA, {13'h0, 3'h2, 16'h000e});
    wr(`TSEQ_CTRL, 32'h51);
    repeat (8) @(posedge sys_clk);
    rd(`TSEQ_STAT); chk(rv[6], 0);
    rd(12'h7fc); chk(rv, 32'h0);
  endtask
  task automatic t_edge;
    wr(`TSEQ_ERISE, 32'h1); wr(`TSEQ_ERISE + 12'h8, 32'h4);
    wr(`TSEQ_EFALL + 12'h8, 32'h2);
    wr(`TSEQ_LVLA, 32'h0c); wr(`TSEQ_LVLA + 12'h8, 32'h0d);
    wr(`TSEQ_CTRL, 32'h51);
    smp(32'h0); smp(32'h1); chk(cur_level, 0);
    wr(`TSEQ_CTRL, 32'h53);
    smp(32'h1); chk(cur_level, 0);
    smp(32'h0); chk(cur_level, 0);
    smp(32'h1); chk(cur_level, 1);
    smp(32'h3); chk(cur_level, 1);
    smp(32'h1); chk(cur_level, 2);
  endtask
  task automatic t_dur;
    wr(`TSEQ_LVLA, 32'h0040_4c40); wr(`TSEQ_LVLB, 32'h3);
    wr(`TSEQ_LVLA + 12'h8, 32'h8000); wr(`TSEQ_LVLB + 12'h8, 32'h2);
    wr(`TSEQ_CTRL, 32'h53);
    smp(32'h11); smp(32'h11); smp(32'h0);
    chk(cur_level, 0);
    smp(32'h11); smp(32'h11); chk(cur_level, 0);
    smp(32'h11); chk(cur_level, 1);
    smp(32'h11); smp(32'h11); smp(32'h11); smp(32'h0);
    chk(cur_level, 1);
    smp(32'h11); smp(32'h11); smp(32'h0);
    chk(cur_level, 2);
  endtask
  task automatic t_cons;
    wr(`TSEQ_LVLA, 32'h0080_0000); wr(`TSEQ_LVLB, 32'h3);
    wr(`TSEQ_LVLA + 12'h8, 32'h0140_0040);
    wr(`TSEQ_CTRL, 32'h59);
    smp(32'h11); chk(store_en, 1);
    smp(32'h11); smp(32'h0); chk(store_en, 0);
    smp(32'h11); chk(cur_level, 0);
    smp(32'h11); smp(32'h11); chk(cur_level, 1);
    smp(32'h11); chk(cur_level, 0);
  endtask
  task automatic t_pause;
    wr(`TSEQ_LVLA, 32'h0001_0000); wr(`TSEQ_LVLB, 32'h0);
    wr(`TSEQ_LVLA + 12'h8, 32'h0003_0000); wr(`TSEQ_LVLB + 12'h8, 32'h0);
    wr(`TSEQ_LVLA + 12'h10, 32'h0004_0000);
    wr(`TSEQ_CTRL, 32'h51);
    smp(32'h11); repeat (10) @(posedge sys_clk);
    rd(`TSEQ_STAT); chk(rv[6], 0);
    smp(32'h11); repeat (8) @(posedge sys_clk);
    rd(`TSEQ_STAT); chk(rv[6], 1);
    chk(rv[3:0], 2);
    smp(32'h11); rd(`TSEQ_STAT); chk(rv[6], 1);
  endtask
  task automatic t_soon;
    wr(`TSEQ_LVLA, 32'h0001_0000);
    wr(`TSEQ_LVLA + 12'h8, lvl(5'h1, 5'h0e, 4'h0, 1'b1));
    wr(`TSEQ_CTRL, 32'h51);
    smp(32'h11); repeat (8) @(posedge sys_clk);
    smp(32'h33); chk(cur_level, 0);
    smp(32'h11); smp(32'h22); chk(cur_level, 2);
  endtask
  // ----------------------------------------------------
  // main sequence and verdict
  // ----------------------------------------------------
  task automatic close_out;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    mismatches = 0; checked = 0; cycles = 0;
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 12'h0; reg_wdata = 32'h0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_branch;
    t_trig;
    t_range;
    t_timer;
    t_edge;
    t_dur;
    t_cons;
    t_pause;
    t_soon;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
